// *** hw/tap_pkg.sv ***
package tap_pkg;

    // ****************************************
    // Instruction encodings
    // ****************************************
    localparam logic [3:0] OP_EXTEST       = 4'h0;
    localparam logic [3:0] OP_CHAIN_SELECT = 4'h2;
    localparam logic [3:0] OP_PRODUCTION   = 4'h3;
    localparam logic [3:0] OP_CLAMP        = 4'h5;
    localparam logic [3:0] OP_HIGHZ        = 4'h7;
    localparam logic [3:0] OP_CLAMP_DIS    = 4'h9;
    localparam logic [3:0] OP_INTEST       = 4'hc;
    localparam logic [3:0] OP_IDCODE       = 4'he;
    localparam logic [3:0] OP_BYPASS       = 4'hf;

    // ****************************************
    // Capture and reset values
    // ****************************************
    localparam logic [3:0] IR_CAPTURE_VALUE    = 4'h1;
    localparam logic [3:0] CHAIN_CAPTURE_VALUE = 4'h8;
    localparam logic [3:0] CHAIN_RESET_VALUE   = 4'h0;
    localparam logic [3:0] IR_RESET_VALUE      = OP_IDCODE;
    localparam logic [2:0] PIN_RESET_VALUE     = 3'h4;
    localparam logic       TCK_RESET_VALUE     = 1'b1;
    localparam int         IR_WIDTH            = 4;
    localparam int         CHAIN_SEL_WIDTH     = 4;
    localparam int         ID_WIDTH            = 32;
    localparam int         SYNC_STAGES         = 2;

    // ****************************************
    // Controller states
    // ****************************************
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_t;

    // Data path selection
    typedef enum logic [1:0] {
        PATH_BYPASS, PATH_IDCODE, PATH_CHAIN_SELECT, PATH_SCAN
    } path_t;

endpackage

// *** hw/pin_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if;
    logic tck_raw;
    logic tms_raw;
    logic tdi_raw;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    modport syncer (input tck_raw, tms_raw, tdi_raw, output tck_s, tms_s, tdi_s);
    modport user   (output tck_raw, tms_raw, tdi_raw, input tck_s, tms_s, tdi_s);
endinterface

`default_nettype wire

// *** hw/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    input  wire logic clk,
    input  wire logic nrst,
    pin_sync_if.syncer sig
);

    // ****************************************
    // Two-stage synchronisers
    // ****************************************
    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.stage1 = {sig.tck_raw, sig.tms_raw, sig.tdi_raw};
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= {tap_pkg::PIN_RESET_VALUE, tap_pkg::PIN_RESET_VALUE};
        end else begin
            s <= next_s;
        end
    end

    assign sig.tck_s = s.stage2[2];
    assign sig.tms_s = s.stage2[1];
    assign sig.tdi_s = s.stage2[0];

endmodule

`default_nettype wire

// *** hw/jtag_instruction_decode.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Instruction register is four bits, without parity.
// - Capture-IR loads 0001 into the instruction register.
// - Inputs sampled on test clock rise; serial out changes on fall.
// - EXTEST routes the selected chain and puts all cells in test mode.
// - EXTEST captures, shifts; Update-DR pulses scan_update to apply shifted bits.
// - Chain select instruction routes select register; capture loads 1000.
// - Chain number shifted in; update selects chain until next chain select.
// - Test logic reset selects scan chain 0.
// - Chain select register is four bits wide.
// - INTEST routes selected chain, test mode, allows single step.
// - INTEST captures core outputs and system inputs, then shifts.
// - IDCODE routes 32-bit identification register, cells in system mode.
// - IDCODE captures fixed code, shifts it; update leaves it alone.
// - BYPASS routes one-bit register, system mode, pins unaffected.
// - Bypass captures 0, one cycle delay, update does nothing.
// - Unassigned codes behave as BYPASS.
// - CLAMP uses bypass; outputs from scan chain values; chain 0 only.
// - HIGHZ uses bypass and floats bus outputs like bus enable low.
// - Disabled clamp uses bypass, disables outputs, data from scan cells.
// - Update-IR makes the register current; shifted least significant first.
// - Test reset low resets asynchronously to system mode and IDCODE.
module jtag_instruction_decode #(
    parameter logic [31:0] ID_CODE = 32'h1234_5001  // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    input  wire logic        scan_tdo,
    output logic             tdo,
    output logic             tdo_oe,
    output logic [3:0]       current_instr,
    output logic [3:0]       active_chain,
    output logic             test_mode,
    output logic             clamp_active,
    output logic             bus_float,
    output logic             run_idle_step,
    output logic             scan_capture,
    output logic             scan_shift,
    output logic             scan_update
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    pin_sync_if pins ();

    assign pins.tck_raw = tck;
    assign pins.tms_raw = tms;
    assign pins.tdi_raw = tdi;

    pin_sync u_sync (
        .clk  (clk),
        .nrst (nrst),
        .sig  (pins)
    );

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        tap_pkg::tap_state_t tap;
        logic                tck_prev;
        logic [3:0]          ir_shift;
        logic [3:0]          ir;
        logic [3:0]          chain_shift;
        logic [3:0]          chain;
        logic [31:0]         id_shift;
        logic                bypass;
        logic                serial_bit;
        logic                tdo;
        logic                tdo_oe;
        logic                test_mode;
        logic                clamp_active;
        logic                bus_float;
        logic                run_idle_step;
        logic                scan_capture;
        logic                scan_shift;
        logic                scan_update;
    } state_t;

    state_t r;
    state_t next_r;

    tap_pkg::path_t path;
    logic           rise;
    logic           fall;

    assign rise = pins.tck_s & ~r.tck_prev;
    assign fall = ~pins.tck_s & r.tck_prev;

    // ****************************************
    // Instruction decode
    // ****************************************
    always_comb begin
        case (r.ir)
            tap_pkg::OP_EXTEST:       path = tap_pkg::PATH_SCAN;
            tap_pkg::OP_INTEST:       path = tap_pkg::PATH_SCAN;
            tap_pkg::OP_CHAIN_SELECT: path = tap_pkg::PATH_CHAIN_SELECT;
            tap_pkg::OP_IDCODE:       path = tap_pkg::PATH_IDCODE;
            tap_pkg::OP_BYPASS:       path = tap_pkg::PATH_BYPASS;
            tap_pkg::OP_CLAMP:        path = tap_pkg::PATH_BYPASS;
            tap_pkg::OP_HIGHZ:        path = tap_pkg::PATH_BYPASS;
            tap_pkg::OP_CLAMP_DIS:    path = tap_pkg::PATH_BYPASS;
            tap_pkg::OP_PRODUCTION:   path = tap_pkg::PATH_BYPASS;
            default:                  path = tap_pkg::PATH_BYPASS;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r               = r;
        next_r.tck_prev      = pins.tck_s;
        next_r.scan_capture  = 1'b0;
        next_r.scan_shift    = 1'b0;
        next_r.scan_update   = 1'b0;
        next_r.run_idle_step = 1'b0;

        if (rise) begin
            // Actions of the state being left
            case (r.tap)
                tap_pkg::CAPTURE_IR: begin
                    next_r.ir_shift = tap_pkg::IR_CAPTURE_VALUE;
                end
                tap_pkg::SHIFT_IR: begin
                    next_r.ir_shift = {pins.tdi_s, r.ir_shift[3:1]};
                end
                tap_pkg::UPDATE_IR: begin
                    next_r.ir = r.ir_shift;
                end
                tap_pkg::CAPTURE_DR: begin
                    case (path)
                        tap_pkg::PATH_CHAIN_SELECT:
                            next_r.chain_shift = tap_pkg::CHAIN_CAPTURE_VALUE;
                        tap_pkg::PATH_IDCODE:
                            next_r.id_shift = ID_CODE;
                        tap_pkg::PATH_SCAN:
                            next_r.scan_capture = 1'b1;
                        default:
                            next_r.bypass = 1'b0;
                    endcase
                end
                tap_pkg::SHIFT_DR: begin
                    case (path)
                        tap_pkg::PATH_CHAIN_SELECT:
                            next_r.chain_shift = {pins.tdi_s, r.chain_shift[3:1]};
                        tap_pkg::PATH_IDCODE:
                            next_r.id_shift = {pins.tdi_s, r.id_shift[31:1]};
                        tap_pkg::PATH_SCAN:
                            next_r.scan_shift = 1'b1;
                        default:
                            next_r.bypass = pins.tdi_s;
                    endcase
                end
                tap_pkg::UPDATE_DR: begin
                    if (path == tap_pkg::PATH_CHAIN_SELECT) begin
                        next_r.chain = r.chain_shift;
                    end
                    if (path == tap_pkg::PATH_SCAN) begin
                        next_r.scan_update = 1'b1;
                    end
                end
                tap_pkg::RUN_TEST_IDLE: begin
                    next_r.run_idle_step = (r.ir == tap_pkg::OP_INTEST);
                end
                default: begin
                end
            endcase

            // Controller transitions
            case (r.tap)
                tap_pkg::TEST_LOGIC_RESET: begin
                    next_r.tap = pins.tms_s ? tap_pkg::TEST_LOGIC_RESET
                                            : tap_pkg::RUN_TEST_IDLE;
                end
                tap_pkg::RUN_TEST_IDLE: begin
                    next_r.tap = pins.tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
                end
                tap_pkg::SELECT_DR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
                end
                tap_pkg::CAPTURE_DR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
                end
                tap_pkg::SHIFT_DR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
                end
                tap_pkg::EXIT1_DR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
                end
                tap_pkg::PAUSE_DR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
                end
                tap_pkg::EXIT2_DR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
                end
                tap_pkg::UPDATE_DR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
                end
                tap_pkg::SELECT_IR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::TEST_LOGIC_RESET
                                            : tap_pkg::CAPTURE_IR;
                end
                tap_pkg::CAPTURE_IR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
                end
                tap_pkg::SHIFT_IR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
                end
                tap_pkg::EXIT1_IR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
                end
                tap_pkg::PAUSE_IR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
                end
                tap_pkg::EXIT2_IR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
                end
                tap_pkg::UPDATE_IR: begin
                    next_r.tap = pins.tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
                end
                default: begin
                    next_r.tap = tap_pkg::TEST_LOGIC_RESET;
                end
            endcase

            // Test logic reset: chain 0 and identification instruction
            if (next_r.tap == tap_pkg::TEST_LOGIC_RESET) begin
                next_r.chain = tap_pkg::CHAIN_RESET_VALUE;
                next_r.ir    = tap_pkg::IR_RESET_VALUE;
            end

            // Serial bit presented at the next falling edge
            case (next_r.tap)
                tap_pkg::SHIFT_IR: next_r.serial_bit = next_r.ir_shift[0];
                tap_pkg::SHIFT_DR: begin
                    case (path)
                        tap_pkg::PATH_CHAIN_SELECT: next_r.serial_bit = next_r.chain_shift[0];
                        tap_pkg::PATH_IDCODE:       next_r.serial_bit = next_r.id_shift[0];
                        tap_pkg::PATH_SCAN:         next_r.serial_bit = 1'b0;
                        default:                    next_r.serial_bit = next_r.bypass;
                    endcase
                end
                default: next_r.serial_bit = 1'b0;
            endcase
        end

        // Serial output moves only on the falling edge
        if (fall) begin
            // Chain settles after its pulse, so read it at the fall
            if ((r.tap == tap_pkg::SHIFT_DR) && (path == tap_pkg::PATH_SCAN)) begin
                next_r.tdo = scan_tdo;
            end else begin
                next_r.tdo = r.serial_bit;
            end
            next_r.tdo_oe = (r.tap == tap_pkg::SHIFT_IR) || (r.tap == tap_pkg::SHIFT_DR);
        end

        // Scan cell modes and pin overrides
        next_r.test_mode    = 1'b0;
        next_r.clamp_active = 1'b0;
        next_r.bus_float    = 1'b0;
        case (next_r.ir)
            tap_pkg::OP_EXTEST: begin
                next_r.test_mode = 1'b1;
            end
            tap_pkg::OP_INTEST: begin
                next_r.test_mode = 1'b1;
            end
            tap_pkg::OP_CLAMP: begin
                next_r.clamp_active = 1'b1;
            end
            tap_pkg::OP_HIGHZ: begin
                next_r.bus_float = 1'b1;
            end
            tap_pkg::OP_CLAMP_DIS: begin
                next_r.clamp_active = 1'b1;
                next_r.bus_float    = 1'b1;
            end
            default: begin
                // System mode
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r       <= '0;
            r.tap   <= tap_pkg::TEST_LOGIC_RESET;
            r.tck_prev <= tap_pkg::TCK_RESET_VALUE;
            r.ir    <= tap_pkg::IR_RESET_VALUE;
            r.chain <= tap_pkg::CHAIN_RESET_VALUE;
        end else begin
            r <= next_r;
        end
    end

    assign tdo           = r.tdo;
    assign tdo_oe        = r.tdo_oe;
    assign current_instr = r.ir;
    assign active_chain  = r.chain;
    assign test_mode     = r.test_mode;
    assign clamp_active  = r.clamp_active;
    assign bus_float     = r.bus_float;
    assign run_idle_step = r.run_idle_step;
    assign scan_capture  = r.scan_capture;
    assign scan_shift    = r.scan_shift;
    assign scan_update   = r.scan_update;

endmodule

`default_nettype wire

// *** test/jtag_instruction_decode_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port checker
// ****************************************
module jtag_decode_checker (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       tck,
    input wire logic       tms,
    input wire logic       tdi,
    input wire logic       scan_tdo,
    input wire logic       tdo,
    input wire logic       tdo_oe,
    input wire logic [3:0] current_instr,
    input wire logic [3:0] active_chain,
    input wire logic       test_mode,
    input wire logic       clamp_active,
    input wire logic       bus_float,
    input wire logic       run_idle_step,
    input wire logic       scan_capture,
    input wire logic       scan_shift,
    input wire logic       scan_update
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_shift_gap;
        !scan_shift [*5];
    endsequence

    property p_reset_vals;
        $rose(nrst) |-> current_instr == tap_pkg::OP_IDCODE && active_chain == 4'h0 && !tdo_oe;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_test_mode;
        $stable(current_instr) |-> test_mode == (current_instr == tap_pkg::OP_EXTEST
                                                 || current_instr == tap_pkg::OP_INTEST);
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("bad mode");

    property p_clamp;
        $stable(current_instr) |-> clamp_active == (current_instr == tap_pkg::OP_CLAMP
                                                    || current_instr == tap_pkg::OP_CLAMP_DIS);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp flag wrong");

    property p_float;
        $stable(current_instr) |-> bus_float == (current_instr == tap_pkg::OP_HIGHZ
                                                 || current_instr == tap_pkg::OP_CLAMP_DIS);
    endproperty
    a_float: assert property (p_float) else $error("float flag wrong");

    property p_tdo_fall;
        ($changed(tdo) || $changed(tdo_oe)) |-> !tck && !$past(tck);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("serial out moved off fall");

    property p_scan_path;
        (scan_capture || scan_shift || scan_update) |->
            (current_instr == tap_pkg::OP_EXTEST || current_instr == tap_pkg::OP_INTEST);
    endproperty
    a_scan_path: assert property (p_scan_path) else $error("chain pulse off scan");

    property p_step;
        run_idle_step |-> current_instr == tap_pkg::OP_INTEST;
    endproperty
    a_step: assert property (p_step) else $error("core step outside intest");

    property p_shift_pulse;
        scan_shift |=> s_shift_gap;
    endproperty
    a_shift_pulse: assert property (p_shift_pulse) else $error("shift pulse too long");

    property p_chain_hold;
        $changed(active_chain) |-> $past(current_instr) == tap_pkg::OP_CHAIN_SELECT
                                   || active_chain == 4'h0;
    endproperty
    a_chain_hold: assert property (p_chain_hold) else $error("bad chain change");

    property p_instr_rise;
        $changed(current_instr) |-> tck && $past(tck);
    endproperty
    a_instr_rise: assert property (p_instr_rise) else $error("instr moved off rise");
endmodule

bind jtag_instruction_decode jtag_decode_checker chk_u (
    .clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .scan_tdo(scan_tdo),
    .tdo(tdo), .tdo_oe(tdo_oe), .current_instr(current_instr), .active_chain(active_chain),
    .test_mode(test_mode), .clamp_active(clamp_active), .bus_float(bus_float),
    .run_idle_step(run_idle_step), .scan_capture(scan_capture), .scan_shift(scan_shift),
    .scan_update(scan_update)
);

`default_nettype wire

// *** test/jtag_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Test host and external chain
// ****************************************
module jtag_host_model #(
    parameter logic [7:0] CHAIN_PAT = 8'ha5
) (
    input  wire logic clk,
    input  wire logic tdo,
    input  wire logic scan_capture,
    input  wire logic scan_shift,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      scan_tdo
);
    logic [7:0] chain;
    logic       ph;

    // All four test inputs always driven
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
        ph = 1'b0;
        chain = CHAIN_PAT;
    end

    // Chain captures pattern, then shifts
    always @(posedge clk) begin
        if (scan_capture === 1'b1)
            chain <= CHAIN_PAT;
        else if (scan_shift === 1'b1)
            chain <= {tdi, chain[7:1]};
    end
    assign scan_tdo = chain[0];

    // Drive on fall, sample out late in low phase
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        tck <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        q = tdo;
        @(posedge clk);
        tck <= 1'b1;
        repeat (ph ? 6 : 5) @(posedge clk);
        ph = ~ph;
    endtask

    // Idle to shift, LSB first, back to idle
    // Callers never load the production-only code
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        repeat (4) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Testbench
// ****************************************
module tb_top;
    localparam logic [31:0] TB_ID = 32'h0bad_c0de;  // Arbitrary value
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       tck, tms, tdi, scan_tdo, tdo, tdo_oe, test_mode, clamp_active, bus_float;
    logic       run_idle_step, scan_capture, scan_shift, scan_update;
    logic [3:0] current_instr, active_chain;
    int         errors = 0;
    int         cmp_count = 0;
    int         steps = 0;
    int         updates = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (run_idle_step === 1'b1) steps <= steps + 1;
    always @(posedge clk) if (scan_update === 1'b1) updates <= updates + 1;

    jtag_instruction_decode #(.ID_CODE(TB_ID)) dut_u (
        .clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .scan_tdo(scan_tdo),
        .tdo(tdo), .tdo_oe(tdo_oe), .current_instr(current_instr),
        .active_chain(active_chain), .test_mode(test_mode), .clamp_active(clamp_active),
        .bus_float(bus_float), .run_idle_step(run_idle_step), .scan_capture(scan_capture),
        .scan_shift(scan_shift), .scan_update(scan_update)
    );

    jtag_host_model host_u (
        .clk(clk), .tdo(tdo), .scan_capture(scan_capture), .scan_shift(scan_shift),
        .tck(tck), .tms(tms), .tdi(tdi), .scan_tdo(scan_tdo)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic load(input logic [3:0] op, output logic [31:0] q);
        host_u.scan(1'b1, 4, {28'h0, op}, q);
    endtask

    task automatic do_reset;
        logic b;
        @(posedge clk) nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        check({current_instr, active_chain}, {tap_pkg::OP_IDCODE, 4'h0});
        check({tdo_oe, test_mode, clamp_active, bus_float}, 4'h0);
        host_u.step(1'b0, 1'b0, b);
    endtask

    task automatic t_idcode;
        logic [31:0] q;
        host_u.scan(1'b0, 32, 32'hffff_ffff, q);
        check(q, TB_ID);
        host_u.scan(1'b0, 32, 32'h0000_0000, q);
        check(q, TB_ID);
        load(tap_pkg::OP_IDCODE, q);
        check(q[3:0], 4'h1);
    endtask

    task automatic t_bypass_family;
        logic [3:0]  ops [6] = '{4'hf, 4'h5, 4'h7, 4'h9, 4'h6, 4'hb};
        logic [31:0] q;
        logic [2:0]  modes;
        foreach (ops[i]) begin
            load(ops[i], q);
            modes = {1'b0, ops[i] == 4'h5 || ops[i] == 4'h9, ops[i] == 4'h7 || ops[i] == 4'h9};
            check(current_instr, ops[i]);
            check({test_mode, clamp_active, bus_float}, modes);
            host_u.scan(1'b0, 4, 32'h0000_000b, q);
            check(q[3:0], 4'h6);
        end
    endtask

    task automatic t_chains;
        logic [31:0] q;
        int          s;
        int          u;
        load(tap_pkg::OP_CHAIN_SELECT, q);
        host_u.scan(1'b0, 4, 32'h0000_0001, q);
        check(q[3:0], 4'h8);
        check(active_chain, 4'h1);
        load(tap_pkg::OP_IDCODE, q);
        check(active_chain, 4'h1);
        load(tap_pkg::OP_EXTEST, q);
        check(test_mode, 1'b1);
        u = updates;
        host_u.scan(1'b0, 8, 32'h0000_003c, q);
        check(q[7:0], 8'ha5);
        check(updates - u, 1);
        load(tap_pkg::OP_INTEST, q);
        check(test_mode, 1'b1);
        s = steps;
        host_u.step(1'b0, 1'b0, q[0]);
        repeat (4) @(posedge clk);
        check(steps - s, 1);
        host_u.scan(1'b0, 8, 32'h0000_00c3, q);
        check(q[7:0], 8'ha5);
    endtask

    task automatic t_logic_reset;
        logic b;
        repeat (5) host_u.step(1'b1, 1'b0, b);
        repeat (4) @(posedge clk);
        check({current_instr, active_chain}, {tap_pkg::OP_IDCODE, 4'h0});
        host_u.step(1'b0, 1'b0, b);
    endtask

    task automatic t_async_reset;
        logic [31:0] q;
        load(tap_pkg::OP_CHAIN_SELECT, q);
        host_u.scan(1'b0, 4, 32'h0000_0002, q);
        check(active_chain, 4'h2);
        do_reset();
    endtask

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        do_reset();
        t_idcode();
        t_bypass_family();
        t_chains();
        t_logic_reset();
        t_async_reset();
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule

`default_nettype wire
